// ==== rtl/csf_status_regs.sv ====
/*
  Read-only charger status bank: timer, temperature zone and protection
  fault registers, read by byte address with a one-cycle registered reply.
  A level change reaches a read reply four clock edges after it happens, so a
  pulse shorter than one clock period may never be seen by the host.
  Unmapped offsets answer zero with RD_ERR; writes are taken and dropped.
  Bits are live images of their levels, so a read never clears them.
  Assumes condition inputs are live levels and the serial bus front end
  presents an address and a read strobe on CLK.
*/
// Operation
// R1 - Pre-charge timeout at timer bit 1
// R2 - Bit 4: battery too low for boost
// R3 - Bit 3: cold zone flag
// R4 - Bit 2: cool zone flag
// R5 - Bit 1: warm zone flag
// R6 - Bit 0 hot; bits 7-5 zero
// R7 - Fault bit 7: discharge current regulating
// R8 - Overvoltage bits 6, 5, 1, 0
// R9 - Overcurrent bits 4, 3, 2
// R10 - Temperature register at 1Fh, reset zero
// R11 - Fault register at 20h, reset zero
// R12 - Timer register at 1Eh, reset zero
// R13 - Bits track synchronised live levels
// R14 - Reserved bits zero, writes ignored
module csf_status_regs
  import csf_pkg::*;
(
  // Clock and reset
  input  wire logic              CLK,
  input  wire logic              RST_N,
  // Read request
  input  wire logic [ADDR_W-1:0] RD_ADDR,
  input  wire logic              RD_EN,
  // Write request, ignored
  input  wire logic [ADDR_W-1:0] WR_ADDR,
  input  wire logic [DATA_W-1:0] WR_DATA,
  input  wire logic              WR_EN,
  // Read reply
  output logic      [DATA_W-1:0] RD_DATA,
  output logic                   RD_VALID,
  output logic                   RD_ERR,
  // Condition levels
  input  wire logic              PRECHARGE_TIMEOUT_FLAG,
  input  wire logic              BATTERY_LOW_FOR_BOOST,
  input  wire logic              COLD_ZONE_FLAG,
  input  wire logic              COOL_ZONE_FLAG,
  input  wire logic              WARM_ZONE_FLAG,
  input  wire logic              HOT_ZONE_FLAG,
  input  wire logic              DISCHARGE_CURRENT_REGULATING,
  input  wire logic              BUS_INPUT_OVERVOLTAGE,
  input  wire logic              BATTERY_OVERVOLTAGE,
  input  wire logic              BUS_INPUT_OVERCURRENT,
  input  wire logic              BATTERY_OVERCURRENT,
  input  wire logic              CONVERTER_OVERCURRENT,
  input  wire logic              SECOND_INPUT_OVERVOLTAGE,
  input  wire logic              FIRST_INPUT_OVERVOLTAGE
);

  logic [N_COND-1:0] cond_raw;
  logic [N_COND-1:0] cond;

  // Synchronised condition levels, one name per status bit
  // The packed vector is read only by the unpacking below
  logic              precharge_sync;
  logic              low_batt_sync;
  logic              cold_sync;
  logic              cool_sync;
  logic              warm_sync;
  logic              hot_sync;
  logic              dis_reg_sync;
  logic              bus_ov_sync;
  logic              batt_ov_sync;
  logic              bus_oc_sync;
  logic              batt_oc_sync;
  logic              conv_oc_sync;
  logic              in2_ov_sync;
  logic              in1_ov_sync;

  logic [DATA_W-1:0] charge_timer_status;
  logic [DATA_W-1:0] temperature_boost_status;
  logic [DATA_W-1:0] protection_fault_status;
  logic [DATA_W-1:0] next_charge_timer_status;
  logic [DATA_W-1:0] next_temperature_boost_status;
  logic [DATA_W-1:0] next_protection_fault_status;

  logic [DATA_W-1:0] next_rd_data;
  logic              next_rd_valid;
  logic              next_rd_err;

  // Write port exists only so a bus write lands harmlessly
  // There is no storage behind these bits that a write could reach
  logic              wr_unused;
  assign wr_unused = WR_EN & (|WR_ADDR) & (|WR_DATA); // see R14

  assign cond_raw = {PRECHARGE_TIMEOUT_FLAG,
                     BATTERY_LOW_FOR_BOOST,
                     COLD_ZONE_FLAG,
                     COOL_ZONE_FLAG,
                     WARM_ZONE_FLAG,
                     HOT_ZONE_FLAG,
                     DISCHARGE_CURRENT_REGULATING,
                     BUS_INPUT_OVERVOLTAGE,
                     BATTERY_OVERVOLTAGE,
                     BUS_INPUT_OVERCURRENT,
                     BATTERY_OVERCURRENT,
                     CONVERTER_OVERCURRENT,
                     SECOND_INPUT_OVERVOLTAGE,
                     FIRST_INPUT_OVERVOLTAGE};

  // Analog levels arrive unrelated to CLK
  // Two flops trade two cycles of delay for a settled level
  csf_sync #(
    .WIDTH (N_COND)
  ) u_sync (
    .clk   (CLK),
    .rst_n (RST_N),
    .d     (cond_raw),
    .q     (cond)
  ); // see R13

  // Unpacked in the order cond_raw was packed
  assign {precharge_sync,
          low_batt_sync,
          cold_sync,
          cool_sync,
          warm_sync,
          hot_sync,
          dis_reg_sync,
          bus_ov_sync,
          batt_ov_sync,
          bus_oc_sync,
          batt_oc_sync,
          conv_oc_sync,
          in2_ov_sync,
          in1_ov_sync} = cond;

  // Every image starts from its reset value, so reserved bits
  // can only ever read zero
  // Timer image: only the pre-charge bit is live; reads never clear it
  always_comb begin
    next_charge_timer_status             = RST_TIMER; // see R14
    next_charge_timer_status[BIT_PRECHG] = precharge_sync; // see R1
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      charge_timer_status <= RST_TIMER; // see R12
    end else begin
      charge_timer_status <= next_charge_timer_status;
    end
  end

  // Temperature image; bits 7 to 5 keep their reset zero
  always_comb begin
    next_temperature_boost_status             = RST_TEMP; // see R6
    next_temperature_boost_status[BIT_BATLOW] = low_batt_sync; // see R2
    next_temperature_boost_status[BIT_COLD]   = cold_sync; // see R3
    next_temperature_boost_status[BIT_COOL]   = cool_sync; // see R4
    next_temperature_boost_status[BIT_WARM]   = warm_sync; // see R5
    next_temperature_boost_status[BIT_HOT]    = hot_sync; // see R6
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      temperature_boost_status <= RST_TEMP; // see R10
    end else begin
      temperature_boost_status <= next_temperature_boost_status;
    end
  end

  // Fault image: over-voltage at 6, 5, 1, 0; over-current at 4, 3, 2
  always_comb begin
    next_protection_fault_status              = RST_FAULT; // see R14
    next_protection_fault_status[BIT_DISREG]  = dis_reg_sync; // see R7
    next_protection_fault_status[BIT_BUSOVP]  = bus_ov_sync; // see R8
    next_protection_fault_status[BIT_BATOVP]  = batt_ov_sync; // see R8
    next_protection_fault_status[BIT_BUSOCP]  = bus_oc_sync; // see R9
    next_protection_fault_status[BIT_BATOCP]  = batt_oc_sync; // see R9
    next_protection_fault_status[BIT_CONVOCP] = conv_oc_sync; // see R9
    next_protection_fault_status[BIT_IN2OVP]  = in2_ov_sync; // see R8
    next_protection_fault_status[BIT_IN1OVP]  = in1_ov_sync; // see R8
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      protection_fault_status <= RST_FAULT; // see R11
    end else begin
      protection_fault_status <= next_protection_fault_status;
    end
  end

  // Read decode; unmapped offsets answer zero with an error flag
  // Reply comes one edge after the strobe; back to back reads allowed
  always_comb begin
    next_rd_data  = RD_IDLE;
    next_rd_valid = RD_EN;
    next_rd_err   = 1'b0;
    if (RD_EN) begin
      case (RD_ADDR)
        OFF_TIMER: next_rd_data = charge_timer_status; // see R12
        OFF_TEMP:  next_rd_data = temperature_boost_status; // see R10
        OFF_FAULT: next_rd_data = protection_fault_status; // see R11
        default:   next_rd_err  = 1'b1;
      endcase
    end
  end

  // Reply registered so every output leaves a flip-flop
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RD_DATA  <= RD_IDLE;
      RD_VALID <= 1'b0;
      RD_ERR   <= 1'b0;
    end else begin
      RD_DATA  <= next_rd_data;
      RD_VALID <= next_rd_valid;
      RD_ERR   <= next_rd_err;
    end
  end

endmodule // csf_status_regs

// ==== rtl/csf_pkg.sv ====
/*
  Constants for the charger status register bank: offsets, bit positions,
  reset values and synchroniser depth.
  Assumes a single clock domain and a byte-wide register read port.
*/
package csf_pkg;

  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned SYNC_LEN = 2;

  // Register offsets
  localparam logic [7:0] OFF_TIMER = 8'h1E;
  localparam logic [7:0] OFF_TEMP  = 8'h1F;
  localparam logic [7:0] OFF_FAULT = 8'h20;

  // Reset values
  localparam logic [7:0] RST_TIMER = 8'h00;
  localparam logic [7:0] RST_TEMP  = 8'h00;
  localparam logic [7:0] RST_FAULT = 8'h00;
  localparam logic [7:0] RD_IDLE   = 8'h00;

  // Timer status bit
  localparam int unsigned BIT_PRECHG = 1;

  // Temperature and low-battery bits
  localparam int unsigned BIT_BATLOW = 4;
  localparam int unsigned BIT_COLD   = 3;
  localparam int unsigned BIT_COOL   = 2;
  localparam int unsigned BIT_WARM   = 1;
  localparam int unsigned BIT_HOT    = 0;

  // Fault bits
  localparam int unsigned BIT_DISREG  = 7;
  localparam int unsigned BIT_BUSOVP  = 6;
  localparam int unsigned BIT_BATOVP  = 5;
  localparam int unsigned BIT_BUSOCP  = 4;
  localparam int unsigned BIT_BATOCP  = 3;
  localparam int unsigned BIT_CONVOCP = 2;
  localparam int unsigned BIT_IN2OVP  = 1;
  localparam int unsigned BIT_IN1OVP  = 0;

  // Number of live condition inputs
  localparam int unsigned N_COND = 14;

endpackage : csf_pkg

// ==== rtl/csf_sync.sv ====
/*
  Two-flop level synchroniser, one bit per lane.
  Assumes inputs are slow levels from analog detection circuits.
*/
module csf_sync
  import csf_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Levels
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_q;

  // First stage feeds only the second
  always_comb begin
    next_meta = d;
    next_q    = meta;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= next_meta;
      q    <= next_q;
    end
  end

endmodule // csf_sync

// ==== bench/csf_monitor.sv ====
/* Read port and live bit checks for the status bank.
   Assumes a bind onto csf_status_regs. */
module csf_monitor
  import csf_pkg::*;
(
  // Clock, reset
  input wire logic       CLK,
  input wire logic       RST_N,
  // Read port
  input wire logic [7:0] RD_ADDR,
  input wire logic       RD_EN,
  input wire logic [7:0] RD_DATA,
  input wire logic       RD_VALID,
  input wire logic       RD_ERR,
  // Conditions
  input wire logic       PRECHARGE_TIMEOUT_FLAG,
  input wire logic       FIRST_INPUT_OVERVOLTAGE
);
  timeunit 1ns;
  timeprecision 1ns;
  logic hit;
  assign hit = RD_ADDR inside {OFF_TIMER, OFF_TEMP, OFF_FAULT};
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  read_answer_a: assert property (RD_EN |=> RD_VALID)
    else $error("read not answered");
  no_spurious_a: assert property (!RD_EN |=> !RD_VALID && !RD_ERR)
    else $error("reply without read");
  idle_zero_a: assert property (!RD_VALID |-> RD_DATA == 8'h00)
    else $error("data not zero when idle");
  unmapped_err_a: assert property (RD_EN && !hit |=> RD_ERR)
    else $error("unmapped read not flagged");
  mapped_ok_a: assert property (RD_EN && hit |=> !RD_ERR)
    else $error("mapped read flagged");
  temp_reserved_a: assert property (RD_EN && RD_ADDR == OFF_TEMP
    |=> RD_DATA[7:5] == 3'h0) else $error("reserved bits set");
  // Five samples: the edge that releases reset still resets the flops
  timeout_live_a: assert property (PRECHARGE_TIMEOUT_FLAG[*5]
    ##0 RD_EN && RD_ADDR == OFF_TIMER |=> RD_DATA[BIT_PRECHG])
    else $error("timeout bit missing");
  ovp_live_a: assert property (FIRST_INPUT_OVERVOLTAGE[*5]
    ##0 RD_EN && RD_ADDR == OFF_FAULT |=> RD_DATA[BIT_IN1OVP])
    else $error("overvoltage bit missing");
endmodule // csf_monitor

bind csf_status_regs csf_monitor u_mon (.CLK(CLK), .RST_N(RST_N),
  .RD_ADDR(RD_ADDR), .RD_EN(RD_EN), .RD_DATA(RD_DATA),
  .RD_VALID(RD_VALID), .RD_ERR(RD_ERR),
  .PRECHARGE_TIMEOUT_FLAG(PRECHARGE_TIMEOUT_FLAG),
  .FIRST_INPUT_OVERVOLTAGE(FIRST_INPUT_OVERVOLTAGE));

// ==== bench/csf_host.sv ====
/* Host model issuing byte reads and writes.
   Assumes the caller serialises its task calls. */
module csf_host (
  // Clock
  input wire logic clk,
  // Requests
  output logic       rd_en,
  output logic [7:0] rd_addr,
  output logic       wr_en,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {rd_en, rd_addr, wr_en, wr_addr, wr_data} = 26'h0;
  task automatic rd(logic [7:0] a);
    @(posedge clk);
    rd_en <= 1'h1;
    rd_addr <= a;
  endtask
  // Released address flips, so no stale value looks valid
  task automatic idle();
    @(posedge clk);
    rd_en <= 1'h0;
    rd_addr <= ~rd_addr;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'h1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'h0;
    wr_data <= ~d;
  endtask
endmodule // csf_host

// ==== bench/testbench.sv ====
/* Bench for csf_status_regs: random levels, queued read checks.
   Assumes csf_host as reader and the bound monitor. */
module testbench
  import csf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'h0, rst_n = 1'h0, rd_en, wr_en, rd_valid, rd_err;
  logic [7:0]  rd_addr, wr_addr, wr_data, rd_data;
  logic [13:0] cond = 14'h3FFF;
  logic [8:0]  exp_q[$];
  int          num_errors = 0, check_count = 0, seed = 1;
  localparam logic [7:0] ADDRS [8] = '{OFF_TIMER, OFF_TEMP, OFF_FAULT,
    OFF_FAULT, 8'h00, 8'h1D, 8'h21, 8'hFF};
  always #2 clk = ~clk;
  csf_host host (.clk(clk), .rd_en(rd_en), .rd_addr(rd_addr),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));
  csf_status_regs DUT (.CLK(clk), .RST_N(rst_n), .RD_ADDR(rd_addr),
    .RD_EN(rd_en), .WR_ADDR(wr_addr), .WR_DATA(wr_data), .WR_EN(wr_en),
    .RD_DATA(rd_data), .RD_VALID(rd_valid), .RD_ERR(rd_err),
    .PRECHARGE_TIMEOUT_FLAG(cond[13]), .BATTERY_LOW_FOR_BOOST(cond[12]),
    .COLD_ZONE_FLAG(cond[11]), .COOL_ZONE_FLAG(cond[10]),
    .WARM_ZONE_FLAG(cond[9]), .HOT_ZONE_FLAG(cond[8]),
    .DISCHARGE_CURRENT_REGULATING(cond[7]),
    .BUS_INPUT_OVERVOLTAGE(cond[6]), .BATTERY_OVERVOLTAGE(cond[5]),
    .BUS_INPUT_OVERCURRENT(cond[4]), .BATTERY_OVERCURRENT(cond[3]),
    .CONVERTER_OVERCURRENT(cond[2]),
    .SECOND_INPUT_OVERVOLTAGE(cond[1]), .FIRST_INPUT_OVERVOLTAGE(cond[0]));
  task automatic check(string name, logic [8:0] seen, logic [8:0] want);
    check_count++;
    if (seen !== want) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, want, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Expected {error, data} from the current levels
  task automatic rd(logic [7:0] a);
    case (a)
      OFF_TIMER: exp_q.push_back({7'h00, cond[13], 1'h0});
      OFF_TEMP:  exp_q.push_back({4'h0, cond[12:8]});
      OFF_FAULT: exp_q.push_back({1'h0, cond[7:0]});
      default:   exp_q.push_back(9'h100);
    endcase
    host.rd(a);
  endtask
  always @(posedge clk)
    if (rd_valid === 1'h1)
      check("read", {rd_err, rd_data},
        exp_q.size() ? exp_q.pop_front() : 9'h1FF);
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    exp_q.push_back(9'h000);
    host.rd(OFF_TEMP);
    exp_q.push_back(9'h000);
    host.rd(OFF_FAULT);
    host.idle();
    for (int k = 0; k < 30; k++) begin
      cond <= 14'($random(seed));
      host.wr(ADDRS[k % 3], 8'($random(seed)));
      repeat (4) @(posedge clk);
      foreach (ADDRS[i]) rd(ADDRS[i]);
      host.idle();
    end
    repeat (3) @(posedge clk);
    check("pending", 9'(exp_q.size()), 9'h000);
    end_of_test();
  end
  initial begin
    #10000;
    num_errors++;
    end_of_test();
  end
endmodule // testbench
